// file: design/rms_pkg.sv
// Package for the reference monitor status block
package rms_pkg;
  // ==========================================
  // Register offsets
  localparam logic [9:0] ADDR_VALID_TIME = 10'h1c3;
  localparam logic [9:0] ADDR_STATUS_MAIN = 10'h300;
  localparam logic [9:0] ADDR_HEALTH = 10'h301;
  localparam logic [9:0] ADDR_IRQ_LOW = 10'h302;
  localparam logic [9:0] ADDR_IRQ_HIGH = 10'h303;
  localparam logic [9:0] ADDR_MASK_MODE = 10'h304;
  localparam logic [9:0] ADDR_MASK_REF_A = 10'h306;
  localparam logic [9:0] ADDR_MASK_REF_B = 10'h307;
  localparam logic [9:0] ADDR_IRQ_CTRL = 10'h012;
  // ==========================================
  // Field positions and widths
  localparam int IRQ_RESET_BIT = 5;
  localparam int VT_WIDTH = 5;
  localparam int CNT_WIDTH = 33;
  // Health field positions within each reference nibble
  localparam int H_VALID = 2;
  localparam int H_LOSS = 1;
  localparam int H_LIMIT = 0;
  localparam int REF_B_BASE = 0;
  localparam int REF_A_BASE = 4;
  // Mode mask bit positions
  localparam int M_ENTER_HOLD = 0;
  localparam int M_LEAVE_HOLD = 1;
  localparam int M_REF_CHANGE = 2;
  // ==========================================
  // Reset values
  localparam logic [4:0] VT_RESET = 5'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic freq_too_high;
    logic freq_too_low;
    logic freq_est_done;
    logic ref_select;
    logic holdover;
    logic phase_lock;
    logic freq_lock;
  } rms_loop_status_type;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rms_bus_req_type;
endpackage : rms_pkg

// file: design/rms_validator.sv
// Validation timer for one reference input
`timescale 1ns/1ps
`default_nettype none
module rms_validator (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] timer_setting,
  input wire logic fault_event,
  input wire logic fault_level,
  output logic valid
);
  typedef struct packed {
    logic [rms_pkg::CNT_WIDTH-1:0] count;
    logic valid;
  } rms_val_state_type;

  rms_val_state_type state_reg;
  rms_val_state_type state_next;
  logic [rms_pkg::CNT_WIDTH-1:0] limit;

  // ==========================================
  // Interval of 2^(setting+1)-1 loop filter clocks
  assign limit = (rms_pkg::CNT_WIDTH'(1) << (timer_setting + 6'h01)) - rms_pkg::CNT_WIDTH'(1);

  always_comb
  begin
    state_next = state_reg;
    if (fault_event || fault_level)
    begin
      state_next.count = '0;
      state_next.valid = 1'b0;
    end
    else if (!state_reg.valid)
    begin
      if (state_reg.count >= limit - rms_pkg::CNT_WIDTH'(1))
        state_next.valid = 1'b1;
      else
        state_next.count = state_reg.count + rms_pkg::CNT_WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign valid = state_reg.valid;
endmodule : rms_validator
`default_nettype wire

// file: design/rms_monitor.sv
// Reference validation and status monitor top
`timescale 1ns/1ps
`default_nettype none
module rms_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic first_reference_input_loss,
  input wire logic first_reference_input_limit,
  input wire logic second_reference_input_loss,
  input wire logic second_reference_input_limit,
  input wire logic freq_too_high_in,
  input wire logic freq_too_low_in,
  input wire logic freq_est_done_in,
  input wire logic ref_select_in,
  input wire logic holdover_in,
  input wire logic phase_lock_in,
  input wire logic freq_lock_in,
  output logic first_reference_input_usable,
  output logic second_reference_input_usable,
  output logic irq_event
);
  typedef struct packed {
    logic [3:0] loss_sync1;
    logic [3:0] loss_sync2;
    logic [6:0] loop_sync1;
    logic [6:0] loop_sync2;
    logic [7:0] health_prev;
    logic [6:0] loop_prev;
    logic [4:0] valid_time;
    logic [7:0] mask_mode;
    logic [7:0] mask_ref_a;
    logic [7:0] mask_ref_b;
    logic [7:0] irq_low;
    logic [7:0] irq_high;
    logic captured;
    logic irq;
    logic [7:0] rdata;
  } rms_state_type;

  rms_state_type state_reg;
  rms_state_type state_next;
  rms_pkg::rms_bus_req_type req;
  rms_pkg::rms_loop_status_type loop_status;
  logic [3:0] fault_pins;
  logic [6:0] loop_pins;
  logic [1:0] ref_valid;
  logic [1:0] ref_loss;
  logic [1:0] ref_limit;
  logic [1:0] loss_event;
  logic [1:0] limit_event;
  logic [7:0] status_main;
  logic [7:0] health;
  logic [3:0] ref_nibble [2];
  logic [5:0] ref_edges [2];
  logic [5:0] ref_mask [2];
  logic [1:0] ref_hit;
  logic hold_enter;
  logic hold_leave;
  logic ref_change;
  logic enter_hit;
  logic leave_hit;
  logic change_hit;
  logic mode_hit;
  logic trigger;
  logic wr_valid_time;
  logic wr_mask_mode;
  logic wr_mask_ref_a;
  logic wr_mask_ref_b;
  logic wr_irq_ctrl;
  logic irq_clear;
  logic capture_now;
  logic [7:0] read_mux;

  // ==========================================
  // Register bus request
  assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

  // ==========================================
  // Raw pin groups ahead of the synchronisers
  assign fault_pins = {second_reference_input_limit,
                       second_reference_input_loss,
                       first_reference_input_limit,
                       first_reference_input_loss};
  assign loop_pins = {freq_too_high_in,
                      freq_too_low_in,
                      freq_est_done_in,
                      ref_select_in,
                      holdover_in,
                      phase_lock_in,
                      freq_lock_in};

  // ==========================================
  // Synchronised inputs
  assign ref_loss[0] = state_reg.loss_sync2[0];
  assign ref_loss[1] = state_reg.loss_sync2[2];
  assign ref_limit[0] = state_reg.loss_sync2[1];
  assign ref_limit[1] = state_reg.loss_sync2[3];
  assign loop_status = rms_pkg::rms_loop_status_type'(state_reg.loop_sync2);

  // ==========================================
  // Validation timers per reference
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ref
      logic fault_edge;
      logic fault_hold;
      assign fault_edge = loss_event[gi] | limit_event[gi];
      assign fault_hold = ref_loss[gi] | ref_limit[gi];
      rms_validator u_val (
        .clk(clk),
        .rst_n(rst_n),
        .timer_setting(state_reg.valid_time),
        .fault_event(fault_edge),
        .fault_level(fault_hold),
        .valid(ref_valid[gi])
      );
    end
  endgenerate

  assign first_reference_input_usable = ref_valid[0];
  assign second_reference_input_usable = ref_valid[1];

  // ==========================================
  // Health nibble per reference
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_health
      assign ref_nibble[gi] = {1'b0,
                               ref_valid[gi],
                               ref_loss[gi],
                               ref_limit[gi]};
    end
  endgenerate

  // ==========================================
  // Live status registers
  assign status_main = {1'b0,
                        loop_status.freq_too_high,
                        loop_status.freq_too_low,
                        loop_status.freq_est_done,
                        loop_status.ref_select,
                        loop_status.holdover,
                        loop_status.phase_lock,
                        loop_status.freq_lock};
  assign health = {ref_nibble[0], ref_nibble[1]};

  // ==========================================
  // Edge detection and masking per reference
  assign ref_mask[0] = state_reg.mask_ref_a[5:0];
  assign ref_mask[1] = state_reg.mask_ref_b[5:0];

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_edge
      logic [2:0] cur;
      logic [2:0] prv;
      logic valid_rise;
      logic valid_fall;
      logic loss_rise;
      logic loss_fall;
      logic limit_rise;
      logic limit_fall;
      assign cur = ref_nibble[gi][2:0];
      assign prv = (gi == 0) ? state_reg.health_prev[6:4] : state_reg.health_prev[2:0];
      assign valid_rise = cur[2] & ~prv[2];
      assign valid_fall = ~cur[2] & prv[2];
      assign loss_rise = cur[1] & ~prv[1];
      assign loss_fall = ~cur[1] & prv[1];
      assign limit_rise = cur[0] & ~prv[0];
      assign limit_fall = ~cur[0] & prv[0];
      assign loss_event[gi] = loss_rise;
      assign limit_event[gi] = limit_rise;
      // Bit order matches the mask: valid, loss, limit; rise above fall
      assign ref_edges[gi] = {valid_rise, valid_fall, loss_rise,
                              loss_fall, limit_rise, limit_fall};
      assign ref_hit[gi] = |(ref_edges[gi] & ref_mask[gi]);
    end
  endgenerate

  // ==========================================
  // Holdover and reference selection events
  assign hold_enter = loop_status.holdover & ~state_reg.loop_prev[2];
  assign hold_leave = ~loop_status.holdover & state_reg.loop_prev[2];
  assign ref_change = loop_status.ref_select ^ state_reg.loop_prev[3];
  assign enter_hit = state_reg.mask_mode[rms_pkg::M_ENTER_HOLD] & hold_enter;
  assign leave_hit = state_reg.mask_mode[rms_pkg::M_LEAVE_HOLD] & hold_leave;
  assign change_hit = state_reg.mask_mode[rms_pkg::M_REF_CHANGE] & ref_change;
  assign mode_hit = enter_hit | leave_hit | change_hit;
  assign trigger = ref_hit[0] | ref_hit[1] | mode_hit;

  // ==========================================
  // Register bus decode
  assign wr_valid_time = req.wr && req.addr == rms_pkg::ADDR_VALID_TIME;
  assign wr_mask_mode = req.wr && req.addr == rms_pkg::ADDR_MASK_MODE;
  assign wr_mask_ref_a = req.wr && req.addr == rms_pkg::ADDR_MASK_REF_A;
  assign wr_mask_ref_b = req.wr && req.addr == rms_pkg::ADDR_MASK_REF_B;
  assign wr_irq_ctrl = req.wr && req.addr == rms_pkg::ADDR_IRQ_CTRL;
  assign irq_clear = wr_irq_ctrl && req.wdata[rms_pkg::IRQ_RESET_BIT];
  // Set wins over clear: a trigger in the clear cycle captures afresh
  assign capture_now = trigger && (!state_reg.captured || irq_clear);

  // ==========================================
  // Read data select
  always_comb
  begin
    read_mux = rms_pkg::BYTE_ZERO;
    case (req.addr)
      rms_pkg::ADDR_VALID_TIME: read_mux = {3'h0, state_reg.valid_time};
      rms_pkg::ADDR_STATUS_MAIN: read_mux = status_main;
      rms_pkg::ADDR_HEALTH: read_mux = health;
      rms_pkg::ADDR_IRQ_LOW: read_mux = state_reg.irq_low;
      rms_pkg::ADDR_IRQ_HIGH: read_mux = state_reg.irq_high;
      rms_pkg::ADDR_MASK_MODE: read_mux = state_reg.mask_mode;
      rms_pkg::ADDR_MASK_REF_A: read_mux = state_reg.mask_ref_a;
      rms_pkg::ADDR_MASK_REF_B: read_mux = state_reg.mask_ref_b;
      default: read_mux = rms_pkg::BYTE_ZERO;
    endcase
  end

  // ==========================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    // Two-stage synchronisers on every pin input
    state_next.loss_sync1 = fault_pins;
    state_next.loss_sync2 = state_reg.loss_sync1;
    state_next.loop_sync1 = loop_pins;
    state_next.loop_sync2 = state_reg.loop_sync1;
    // History for edge detection
    state_next.health_prev = health;
    state_next.loop_prev = state_reg.loop_sync2;
    // Software registers
    if (wr_valid_time)
    begin
      state_next.valid_time = req.wdata[4:0];
    end
    if (wr_mask_mode)
    begin
      state_next.mask_mode = {5'h00, req.wdata[2:0]};
    end
    if (wr_mask_ref_a)
    begin
      state_next.mask_ref_a = {2'h0, req.wdata[5:0]};
    end
    if (wr_mask_ref_b)
    begin
      state_next.mask_ref_b = {2'h0, req.wdata[5:0]};
    end
    // Interrupt clear
    if (irq_clear)
    begin
      state_next.irq = 1'b0;
      state_next.captured = 1'b0;
      state_next.irq_low = rms_pkg::BYTE_ZERO;
      state_next.irq_high = rms_pkg::BYTE_ZERO;
    end
    // Interrupt set and snapshot
    if (trigger)
    begin
      state_next.irq = 1'b1;
    end
    if (capture_now)
    begin
      state_next.captured = 1'b1;
      state_next.irq_low = status_main;
      state_next.irq_high = health;
    end
    // Read data stands one cycle after the strobe
    if (req.rd)
    begin
      state_next.rdata = read_mux;
    end
    else
    begin
      state_next.rdata = rms_pkg::BYTE_ZERO;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg.loss_sync1 <= '0;
      state_reg.loss_sync2 <= '0;
      state_reg.loop_sync1 <= '0;
      state_reg.loop_sync2 <= '0;
      state_reg.health_prev <= rms_pkg::BYTE_ZERO;
      state_reg.loop_prev <= '0;
      state_reg.valid_time <= rms_pkg::VT_RESET;
      state_reg.mask_mode <= rms_pkg::MASK_RESET;
      state_reg.mask_ref_a <= rms_pkg::MASK_RESET;
      state_reg.mask_ref_b <= rms_pkg::MASK_RESET;
      state_reg.irq_low <= rms_pkg::BYTE_ZERO;
      state_reg.irq_high <= rms_pkg::BYTE_ZERO;
      state_reg.captured <= 1'b0;
      state_reg.irq <= 1'b0;
      state_reg.rdata <= rms_pkg::BYTE_ZERO;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Outputs
  assign rdata = state_reg.rdata;
  assign irq_event = state_reg.irq;
endmodule : rms_monitor
`default_nettype wire

// file: verif/rms_monitor_properties.sv
// Port checker of the reference monitor
`timescale 1ns/1ps
`default_nettype none
module rms_monitor_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic first_reference_input_loss,
  input wire logic first_reference_input_limit,
  input wire logic second_reference_input_loss,
  input wire logic second_reference_input_limit,
  input wire logic first_reference_input_usable,
  input wire logic second_reference_input_usable,
  input wire logic irq_event
);
  // ==========
  // Shadow of timer setting and fault-free counts
  logic [4:0] vt_reg;
  logic [15:0] ca_reg;
  logic [15:0] cb_reg;
  logic [32:0] lim;
  logic fa;
  logic fb;
  assign lim = (33'h2 << vt_reg) - 33'h1;
  assign fa = first_reference_input_loss | first_reference_input_limit;
  assign fb = second_reference_input_loss | second_reference_input_limit;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Synchronisers leave reset already clear, so two counts are credited
      vt_reg <= 5'h00;
      ca_reg <= 16'h0002;
      cb_reg <= 16'h0002;
    end
    else
    begin
      if (wr_en && addr == rms_pkg::ADDR_VALID_TIME)
        vt_reg <= wdata[4:0];
      ca_reg <= fa ? 16'h0000 : ca_reg + {15'h0000, ~&ca_reg};
      cb_reg <= fb ? 16'h0000 : cb_reg + {15'h0000, ~&cb_reg};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("rdata not zero outside a read");
  a_vt_readback: assert property ($past(rd_en && addr == rms_pkg::ADDR_VALID_TIME)
    |-> rdata == {3'h0, $past(vt_reg)}) else $error("timer setting readback wrong");
  a_loss_blocks: assert property (first_reference_input_loss [*4]
    |=> !first_reference_input_usable) else $error("first usable during loss");
  a_limit_blocks: assert property (second_reference_input_limit [*4]
    |=> !second_reference_input_usable) else $error("second usable during limit");
  a_early_first: assert property ($rose(first_reference_input_usable)
    |-> ca_reg >= lim + 1) else $error("first valid too early");
  a_early_second: assert property ($rose(second_reference_input_usable)
    |-> cb_reg >= lim + 1) else $error("second valid too early");
  a_late_first: assert property (ca_reg == lim + 5
    |-> first_reference_input_usable) else $error("first valid too late");
  a_late_second: assert property (cb_reg == lim + 5
    |-> second_reference_input_usable) else $error("second valid too late");
  a_irq_holds: assert property (irq_event && !(wr_en && addr == rms_pkg::ADDR_IRQ_CTRL
    && wdata[5]) |=> irq_event) else $error("irq dropped without reset");
  c_irq: cover property ($rose(irq_event));
  c_first_ok: cover property ($rose(first_reference_input_usable));
  c_second_bad: cover property ($fell(second_reference_input_usable));
endmodule : rms_monitor_chk
bind rms_monitor rms_monitor_chk u_rms_monitor_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq_event(irq_event),
  .first_reference_input_loss(first_reference_input_loss),
  .first_reference_input_limit(first_reference_input_limit),
  .second_reference_input_loss(second_reference_input_loss),
  .second_reference_input_limit(second_reference_input_limit),
  .first_reference_input_usable(first_reference_input_usable),
  .second_reference_input_usable(second_reference_input_usable));
`default_nettype wire

// file: verif/rms_ref_model.sv
// Model of the two monitored reference sources
`timescale 1ns/1ps
`default_nettype none
module rms_ref_model (
  input wire logic clk,
  output logic [3:0] fault
);
  // ==========
  // Fault levels: first loss, first limit, second loss, second limit
  initial fault = 4'h0;
  task automatic set_fault(input logic [3:0] f);
    @(posedge clk);
    fault <= f;
  endtask : set_fault
endmodule : rms_ref_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the reference monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [6:0] st;
  logic [7:0] rdata;
  logic [3:0] f;
  logic u_a;
  logic u_b;
  logic irq;
  int checks = 0;
  int n_mismatch = 0;
  always #2 clk = ~clk;
  rms_ref_model u_rms_ref_model (.clk(clk), .fault(f));
  rms_monitor u_rms_monitor (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .first_reference_input_loss(f[3]),
    .first_reference_input_limit(f[2]), .second_reference_input_loss(f[1]),
    .second_reference_input_limit(f[0]), .freq_too_high_in(st[6]), .freq_too_low_in(st[5]),
    .freq_est_done_in(st[4]), .ref_select_in(st[3]), .holdover_in(st[2]),
    .phase_lock_in(st[1]), .freq_lock_in(st[0]), .first_reference_input_usable(u_a),
    .second_reference_input_usable(u_b), .irq_event(irq));
  // ==========
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp($sformatf("rdata %h", a), e, rdata & m);
    @(posedge clk);
  endtask : rdc
  task automatic wait_use(input logic b, input int lo, input int hi);
    int n;
    n = 0;
    while ((b ? u_b : u_a) !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 300)
      begin
        n_mismatch++;
        complete_run();
      end
    end
    cmp("valid delay", 8'h01, {7'h00, n >= lo && n <= hi});
  endtask : wait_use
  // ==========
  // Scenarios
  task automatic t_regs();
    wr(rms_pkg::ADDR_VALID_TIME, 8'hff);
    rdc(rms_pkg::ADDR_VALID_TIME, 8'hff, 8'h1f);
    rdc(rms_pkg::ADDR_IRQ_LOW, 8'hff, 8'h00);
    rdc(10'h3ff, 8'hff, 8'h00);
    rdc(rms_pkg::ADDR_HEALTH, 8'hff, 8'h44);
  endtask : t_regs
  task automatic t_status();
    for (int i = 0; i < 7; i++)
    begin
      st <= 7'h01 << i;
      repeat (4) @(posedge clk);
      rdc(rms_pkg::ADDR_STATUS_MAIN, 8'hff, 8'h01 << i);
    end
    st <= 7'h00;
  endtask : t_status
  task automatic t_valid();
    wr(rms_pkg::ADDR_VALID_TIME, 8'h02);
    u_rms_ref_model.set_fault(4'h8);
    repeat (4) @(posedge clk);
    rdc(rms_pkg::ADDR_HEALTH, 8'hff, 8'h24);
    cmp("first usable", 8'h00, {7'h00, u_a});
    u_rms_ref_model.set_fault(4'h0);
    wait_use(1'b0, 8, 13);
    wr(rms_pkg::ADDR_VALID_TIME, 8'h03);
    u_rms_ref_model.set_fault(4'h1);
    repeat (4) @(posedge clk);
    rdc(rms_pkg::ADDR_HEALTH, 8'hff, 8'h41);
    u_rms_ref_model.set_fault(4'h0);
    repeat (6) @(posedge clk);
    u_rms_ref_model.set_fault(4'h1);
    u_rms_ref_model.set_fault(4'h0);
    wait_use(1'b1, 16, 21);
  endtask : t_valid
  task automatic t_irq();
    wr(rms_pkg::ADDR_MASK_REF_A, 8'h08);
    st <= 7'h04;
    repeat (4) @(posedge clk);
    u_rms_ref_model.set_fault(4'h8);
    repeat (5) @(posedge clk);
    cmp("irq", 8'h01, {7'h00, irq});
    st <= 7'h00;
    rdc(rms_pkg::ADDR_IRQ_LOW, 8'hff, 8'h04);
    rdc(rms_pkg::ADDR_IRQ_HIGH, 8'h20, 8'h20);
    u_rms_ref_model.set_fault(4'h0);
    repeat (4) @(posedge clk);
    cmp("irq", 8'h01, {7'h00, irq});
    wr(rms_pkg::ADDR_IRQ_CTRL, 8'h20);
    @(posedge clk);
    cmp("irq", 8'h00, {7'h00, irq});
    rdc(rms_pkg::ADDR_IRQ_LOW, 8'hff, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(rms_pkg::ADDR_MASK_MODE, 8'h01 << i);
      st <= st ^ ((i == 2) ? 7'h08 : 7'h04);
      repeat (5) @(posedge clk);
      cmp("mode irq", 8'h01, {7'h00, irq});
      wr(rms_pkg::ADDR_IRQ_CTRL, 8'h20);
    end
  endtask : t_irq
  initial
  begin
    rst_n <= 1'b0;
    addr <= 10'h000;
    wdata <= 8'h00;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    st <= 7'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_status();
    t_valid();
    t_irq();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
